// *** rtl/daqtp_pin_io.sv ***
`timescale 1ns/1ps
module daqtp_pin_io (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [daqtp_pkg::PIN_N-1:0] pin_in,
  output logic [daqtp_pkg::PIN_N-1:0] pin_out,
  output logic [daqtp_pkg::PIN_N-1:0] pin_oe_n,
  output logic [daqtp_pkg::PIN_N-1:0] pin_sync,
  input wire logic [daqtp_pkg::PIN_N-1:0] pin_dir_out,
  input wire logic [daqtp_pkg::CTR_SEL_N-1:0][daqtp_pkg::SEL_W-1:0] ctr_sel_code,
  input wire logic [daqtp_pkg::INT_SRC_N-1:0] int_src,
  output logic [daqtp_pkg::CTR_SEL_N-1:0] ctr_sel_q,
  input wire logic pretrig_mode,
  input wire logic acq_seq_start,
  input wire logic pretrig_conv_begin,
  input wire logic posttrig_conv_begin,
  input wire logic conv_busy,
  input wire logic ao_update,
  input wire logic wfm_gen_start,
  input wire logic scan_start,
  input wire logic scan_mode,
  input wire logic scan_clk_en,
  input wire logic conv_start,
  input wire logic adc_hold_done,
  output logic scan_conversion_clock,
  input wire logic strobe_wr,
  input wire logic strobe_val,
  input wire logic strobe_toggle,
  output logic external_strobe_out_n,
  input wire logic ctr_a_out_int,
  input wire logic ctr_b_out_int,
  input wire logic freq_gen_int,
  output logic counter_a_output,
  output logic counter_b_output,
  output logic freq_generator_output
);
  import daqtp_pkg::*;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Pin inputs cross from the connector: two flops before any use
  logic [PIN_N-1:0] pin_meta_ff;
  logic [PIN_N-1:0] pin_sync_ff;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end
    else
    begin
      pin_meta_ff <= pin_in;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  assign pin_sync = pin_sync_ff;

  // Counter source and gate selection, one selector per slot
  daqtp_sel_if sel_if [CTR_SEL_N] ();

  for (genvar s = 0; s < CTR_SEL_N; s++)
  begin : g_sel
    assign sel_if[s].pin_sync = pin_sync_ff;
    assign sel_if[s].int_src = int_src;
    assign sel_if[s].code = ctr_sel_code[s];
    assign ctr_sel_q[s] = sel_if[s].sel_q;
    daqtp_src_mux u_mux (
      .clk(clk),
      .nrst(nrst),
      .sel_if(sel_if[s])
    );
  end

  // Event pulse stretchers; a repeat inside the width extends the pulse
  wire logic [EV_N-1:0] ev_vec;
  wire logic [EV_N-1:0] str_on;
  wire logic [EV_N-1:0][CNT_W-1:0] str_len;
  wire logic [EV_N-1:0][CNT_W-1:0] nxt_str_cnt;
  logic [EV_N-1:0][CNT_W-1:0] str_cnt_ff;

  assign ev_vec[EV_START] = pretrig_mode ? pretrig_conv_begin : acq_seq_start;
  assign ev_vec[EV_STOP] = pretrig_mode & posttrig_conv_begin;
  assign ev_vec[EV_UPD] = ao_update;
  assign ev_vec[EV_WFM] = wfm_gen_start;
  assign ev_vec[EV_SCAN] = scan_start;

  for (genvar e = 0; e < EV_N; e++)
  begin : g_str
    assign str_len[e] = CNT_W'(TRIG_CYC);
    assign str_on[e] = str_cnt_ff[e] != '0;
    assign nxt_str_cnt[e] = ev_vec[e] ? str_len[e] :
                            str_on[e] ? str_cnt_ff[e] - 1'h1 : '0;
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
        str_cnt_ff[e] <= '0;
      else
        str_cnt_ff[e] <= nxt_str_cnt[e];
    end
  end

  // Function levels as they would appear on their pins
  wire logic acq_start_trigger;
  wire logic acq_stop_trigger;
  wire logic conv_pulse_n;
  wire logic ao_refresh_n;
  wire logic waveform_start_trigger;
  wire logic scan_begin_pulse;
  wire logic [PIN_N-1:0] fn_lvl;

  assign acq_start_trigger = str_on[EV_START];
  // Gated by mode too, so a mode change cannot leave a stray stop pulse
  assign acq_stop_trigger = str_on[EV_STOP] & pretrig_mode;
  assign conv_pulse_n = ~conv_busy;
  assign ao_refresh_n = ~str_on[EV_UPD];
  assign waveform_start_trigger = str_on[EV_WFM];
  assign scan_begin_pulse = str_on[EV_SCAN];

  assign fn_lvl[PIN_START] = acq_start_trigger;
  assign fn_lvl[PIN_STOP] = acq_stop_trigger;
  assign fn_lvl[PIN_CONV] = conv_pulse_n;
  assign fn_lvl[PIN_B_SRC] = ctr_sel_q[SEL_B_SRC];
  assign fn_lvl[PIN_B_GATE] = ctr_sel_q[SEL_B_GATE];
  assign fn_lvl[PIN_UPD] = ao_refresh_n;
  assign fn_lvl[PIN_WFM] = waveform_start_trigger;
  assign fn_lvl[PIN_SCAN] = scan_begin_pulse;
  assign fn_lvl[PIN_A_SRC] = ctr_sel_q[SEL_A_SRC];
  assign fn_lvl[PIN_A_GATE] = ctr_sel_q[SEL_A_GATE];

  // Pin drivers; an undriven pin holds its data low so nothing leaks out
  logic [PIN_N-1:0] pin_out_ff;
  logic [PIN_N-1:0] pin_oe_n_ff;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_out_ff <= '0;
      pin_oe_n_ff <= OE_N_RST;
    end
    else
    begin
      pin_out_ff <= fn_lvl & pin_dir_out;
      pin_oe_n_ff <= ~pin_dir_out;
    end
  end

  assign pin_out = pin_out_ff;
  assign pin_oe_n = pin_oe_n_ff;

  // Scan clock: armed by a conversion, fired once the sample is held
  daqtp_scan_st_t scan_st_ff;
  daqtp_scan_st_t nxt_scan_st;
  logic [CNT_W-1:0] scan_cnt_ff;
  logic [CNT_W-1:0] nxt_scan_cnt;
  logic scan_pend_ff;
  logic nxt_scan_pend;
  logic scan_clk_ff;
  wire logic scan_go;

  assign scan_go = scan_mode & scan_clk_en;

  always_comb
  begin
    nxt_scan_st = scan_st_ff;
    nxt_scan_cnt = scan_cnt_ff;
    nxt_scan_pend = scan_pend_ff;
    unique case (scan_st_ff)
      SC_IDLE:
      begin
        nxt_scan_pend = 1'h0;
        if (scan_go && conv_start)
          nxt_scan_st = SC_ARMED;
      end
      SC_ARMED:
      begin
        if (!scan_go)
          nxt_scan_st = SC_IDLE;
        else if (adc_hold_done)
        begin
          nxt_scan_st = SC_HIGH;
          nxt_scan_cnt = CNT_W'(SCAN_HI_CYC - 1);
        end
      end
      SC_HIGH:
      begin
        // A running pulse always completes: no runt edges on disable
        if (scan_go && conv_start)
          nxt_scan_pend = 1'h1;
        if (scan_cnt_ff != '0)
          nxt_scan_cnt = scan_cnt_ff - 1'h1;
        else if (scan_go && (scan_pend_ff || conv_start))
        begin
          nxt_scan_st = SC_ARMED;
          nxt_scan_pend = 1'h0;
        end
        else
        begin
          nxt_scan_st = SC_IDLE;
          nxt_scan_pend = 1'h0;
        end
      end
      default:
        nxt_scan_st = SC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scan_st_ff <= SC_IDLE;
      scan_cnt_ff <= '0;
      scan_pend_ff <= 1'h0;
      scan_clk_ff <= 1'h0;
    end
    else
    begin
      scan_st_ff <= nxt_scan_st;
      scan_cnt_ff <= nxt_scan_cnt;
      scan_pend_ff <= nxt_scan_pend;
      scan_clk_ff <= nxt_scan_st == SC_HIGH;
    end
  end

  assign scan_conversion_clock = scan_clk_ff;

  // Software strobe; a write outranks a toggle in the same cycle
  logic strobe_ff;
  wire logic nxt_strobe;

  assign nxt_strobe = strobe_wr ? strobe_val : strobe_toggle ? ~strobe_ff : strobe_ff;

  // Dedicated outputs, one register stage each
  logic ctr_a_ff;
  logic ctr_b_ff;
  logic freq_ff;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      strobe_ff <= STROBE_RST;
      ctr_a_ff <= 1'h0;
      ctr_b_ff <= 1'h0;
      freq_ff <= 1'h0;
    end
    else
    begin
      strobe_ff <= nxt_strobe;
      ctr_a_ff <= ctr_a_out_int;
      ctr_b_ff <= ctr_b_out_int;
      freq_ff <= freq_gen_int;
    end
  end

  assign external_strobe_out_n = strobe_ff;
  assign counter_a_output = ctr_a_ff;
  assign counter_b_output = ctr_b_ff;
  assign freq_generator_output = freq_ff;

  scan_fire_a: assert property (
    (scan_st_ff == SC_ARMED && scan_go && adc_hold_done)
      |=> $rose(scan_conversion_clock) ##1 scan_conversion_clock[*7] ##1 !scan_conversion_clock)
    else $error("scan clock pulse missing or wrong width");

  scan_edge_a: assert property (
    $rose(scan_conversion_clock) |-> $past(adc_hold_done))
    else $error("scan clock rose before sample hold");

  strobe_sw_a: assert property (
    (!strobe_wr && !strobe_toggle) |=> $stable(external_strobe_out_n))
    else $error("strobe moved without a command");

  pin_sync_a: assert property (
    ##2 1'h1 |-> pin_sync == $past(pin_in, 2))
    else $error("function pin input not seen after two stages");

  start_post_a: assert property (
    (acq_seq_start && !pretrig_mode) ##1 pin_dir_out[PIN_START] |=> pin_out[PIN_START])
    else $error("start trigger missed post-trigger start");

  start_pre_a: assert property (
    (pretrig_conv_begin && pretrig_mode) ##1 pin_dir_out[PIN_START] |=> pin_out[PIN_START])
    else $error("start trigger missed pre-trigger conversions");

  stop_pre_a: assert property (
    (posttrig_conv_begin && pretrig_mode) ##1 (pin_dir_out[PIN_STOP] && pretrig_mode)
      |=> pin_out[PIN_STOP])
    else $error("stop trigger missed post-trigger conversions");

  stop_idle_a: assert property (
    !pretrig_mode |=> !pin_out[PIN_STOP])
    else $error("stop trigger active in post-trigger mode");

  conv_low_a: assert property (
    (conv_busy && pin_dir_out[PIN_CONV]) |=> !pin_out[PIN_CONV])
    else $error("convert pin high during conversion");

  ctr_b_mirror_a: assert property (
    pin_dir_out[PIN_B_SRC] && pin_dir_out[PIN_B_GATE]
      |=> pin_out[PIN_B_SRC] == $past(ctr_sel_q[SEL_B_SRC])
          && pin_out[PIN_B_GATE] == $past(ctr_sel_q[SEL_B_GATE]))
    else $error("counter b pins differ from selection");

  ctr_a_mirror_a: assert property (
    pin_dir_out[PIN_A_SRC] && pin_dir_out[PIN_A_GATE]
      |=> pin_out[PIN_A_SRC] == $past(ctr_sel_q[SEL_A_SRC])
          && pin_out[PIN_A_GATE] == $past(ctr_sel_q[SEL_A_GATE]))
    else $error("counter a pins differ from selection");

  ctr_b_out_a: assert property (
    1'h1 |=> counter_b_output == $past(ctr_b_out_int))
    else $error("counter b output not following counter");

  ctr_a_out_a: assert property (
    1'h1 |=> counter_a_output == $past(ctr_a_out_int))
    else $error("counter a output not following counter");

  update_low_a: assert property (
    ao_update ##1 pin_dir_out[PIN_UPD] |=> !pin_out[PIN_UPD])
    else $error("update pin did not fall");

  wfm_start_a: assert property (
    wfm_gen_start ##1 pin_dir_out[PIN_WFM] |=> pin_out[PIN_WFM])
    else $error("waveform trigger did not rise");

  scan_begin_a: assert property (
    scan_start ##1 pin_dir_out[PIN_SCAN] |=> pin_out[PIN_SCAN])
    else $error("scan begin pin did not pulse");

  freq_generator_output_a: assert property (
    1'h1 |=> freq_generator_output == $past(freq_gen_int))
    else $error("frequency pin not following generator");

  pin_dir_a: assert property (
    1'h1 |=> pin_oe_n == ~$past(pin_dir_out) && (pin_out & pin_oe_n) == '0)
    else $error("pin direction or idle data wrong");

endmodule

// *** rtl/daqtp_pkg.sv ***
package daqtp_pkg;

  // Pin and selector geometry
  localparam int PIN_N = 10;
  localparam int SEL_W = 4;
  localparam int CTR_SEL_N = 4;
  localparam int INT_SRC_N = 4;
  localparam int CNT_W = 4;

  // Pin positions of the timing functions
  localparam int PIN_START = 0;
  localparam int PIN_STOP = 1;
  localparam int PIN_CONV = 2;
  localparam int PIN_B_SRC = 3;
  localparam int PIN_B_GATE = 4;
  localparam int PIN_UPD = 5;
  localparam int PIN_WFM = 6;
  localparam int PIN_SCAN = 7;
  localparam int PIN_A_SRC = 8;
  localparam int PIN_A_GATE = 9;

  // Counter selector slots
  localparam int SEL_A_SRC = 0;
  localparam int SEL_A_GATE = 1;
  localparam int SEL_B_SRC = 2;
  localparam int SEL_B_GATE = 3;

  // Pulse stretcher slots
  localparam int EV_START = 0;
  localparam int EV_STOP = 1;
  localparam int EV_UPD = 2;
  localparam int EV_WFM = 3;
  localparam int EV_SCAN = 4;
  localparam int EV_N = 5;

  // Timing, least widths rounded up to whole cycles
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SCAN_HI_NS = 400;
  localparam int unsigned TRIG_PULSE_NS = 100;
  localparam int unsigned SCAN_HI_CYC = (SCAN_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TRIG_CYC = (TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Values after reset
  localparam logic STROBE_RST = 1'h1;
  localparam logic [PIN_N-1:0] OE_N_RST = 10'h3ff;

  typedef enum logic [1:0] {SC_IDLE, SC_ARMED, SC_HIGH} daqtp_scan_st_t;

endpackage

// *** rtl/daqtp_sel_if.sv ***
`timescale 1ns/1ps
interface daqtp_sel_if;
  logic [daqtp_pkg::PIN_N-1:0] pin_sync;
  logic [daqtp_pkg::INT_SRC_N-1:0] int_src;
  logic [daqtp_pkg::SEL_W-1:0] code;
  logic sel_q;
  modport drv (output pin_sync, output int_src, output code, input sel_q);
  modport mux (input pin_sync, input int_src, input code, output sel_q);
endinterface

// *** rtl/daqtp_src_mux.sv ***
`timescale 1ns/1ps
module daqtp_src_mux (
  input wire logic clk,
  input wire logic nrst,
  daqtp_sel_if.mux sel_if
);
  import daqtp_pkg::*;

  localparam int IDX_W = $clog2(INT_SRC_N);

  // Codes 0..9 pick a pin, the next four an internal source, others read low
  wire logic pick_pin;
  wire logic pick_int;
  wire logic [SEL_W-1:0] int_off;
  wire logic nxt_sel;

  assign pick_pin = sel_if.code < SEL_W'(PIN_N);
  assign pick_int = sel_if.code < SEL_W'(PIN_N + INT_SRC_N);
  assign int_off = sel_if.code - SEL_W'(PIN_N);
  assign nxt_sel = pick_pin ? sel_if.pin_sync[sel_if.code] :
                   pick_int ? sel_if.int_src[int_off[IDX_W-1:0]] : 1'h0;

  // The registered choice is both the counter input and the mirrored pin
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sel_if.sel_q <= 1'h0;
    else
      sel_if.sel_q <= nxt_sel;
  end

endmodule

// *** bench/daqtp_conn_model.sv ***
`timescale 1ns/1ps
module daqtp_conn_model (
  input wire logic [daqtp_pkg::PIN_N-1:0] pin_out,
  input wire logic [daqtp_pkg::PIN_N-1:0] pin_oe_n,
  input wire logic [daqtp_pkg::PIN_N-1:0] ext_en,
  input wire logic [daqtp_pkg::PIN_N-1:0] ext_val,
  output logic [daqtp_pkg::PIN_N-1:0] pin_in
);
  import daqtp_pkg::*;
  // Equipment drives only where asked; a pin left floating reads high through its pull-up
  always_comb
    for (int i = 0; i < PIN_N; i++)
      pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'h1);
endmodule

// *** bench/daqtp_pin_io_test.sv ***
`timescale 1ns/1ps
module daqtp_pin_io_test;
  import daqtp_pkg::*;
  logic clk;
  logic nrst;
  logic [PIN_N-1:0] pin_in, pin_out, pin_oe_n, pin_sync, dir, ext_en, ext_val;
  logic [CTR_SEL_N-1:0][SEL_W-1:0] code;
  logic [INT_SRC_N-1:0] int_src, sel_q;
  logic [9:0] pulses;
  logic pre, busy, s_mode, s_en, s_val, a_in, b_in, f_in;
  logic scan_clk, strobe_n, a_out, b_out, f_out;
  int errors, check_count, cycles;
  int hi [PIN_N+1];
  int rises [PIN_N+1];

  daqtp_pin_io daqtp_pin_io_inst (.clk(clk), .nrst(nrst), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_sync(pin_sync), .pin_dir_out(dir),
    .ctr_sel_code(code), .int_src(int_src), .ctr_sel_q(sel_q), .pretrig_mode(pre),
    .acq_seq_start(pulses[0]), .pretrig_conv_begin(pulses[1]),
    .posttrig_conv_begin(pulses[2]), .conv_busy(busy), .ao_update(pulses[3]),
    .wfm_gen_start(pulses[4]), .scan_start(pulses[5]), .scan_mode(s_mode),
    .scan_clk_en(s_en), .conv_start(pulses[6]), .adc_hold_done(pulses[7]),
    .scan_conversion_clock(scan_clk), .strobe_wr(pulses[8]), .strobe_val(s_val),
    .strobe_toggle(pulses[9]), .external_strobe_out_n(strobe_n), .ctr_a_out_int(a_in),
    .ctr_b_out_int(b_in), .freq_gen_int(f_in), .counter_a_output(a_out),
    .counter_b_output(b_out), .freq_generator_output(f_out));

  daqtp_conn_model daqtp_conn_model_inst (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One-cycle pulse on the chosen event inputs
  task automatic fire(input logic [9:0] m);
    pulses = m;
    step(1);
    pulses = 10'h000;
  endtask

  // Counts high cycles and rising edges per pin, scan clock in the last slot
  // An optional pulse is raised with the first watched edge, so a 1-cycle answer is seen
  task automatic watch(input int n, input logic [9:0] m = 10'h000);
    logic [PIN_N:0] prev, cur;
    prev = {scan_clk, pin_out};
    if (m != 10'h000)
      pulses = m;
    for (int i = 0; i <= PIN_N; i++)
    begin
      hi[i] = 0;
      rises[i] = 0;
    end
    repeat (n)
    begin
      step(1);
      if (pulses != 10'h000)
        pulses = 10'h000;
      cur = {scan_clk, pin_out};
      for (int i = 0; i <= PIN_N; i++)
      begin
        hi[i] += cur[i];
        rises[i] += cur[i] & ~prev[i];
      end
      prev = cur;
    end
  endtask

  task automatic t_post();
    pre = 1'h0;
    fire(10'h001);
    watch(8);
    chk(hi[PIN_START], TRIG_CYC);
    chk(rises[PIN_START], 1);
    chk(hi[PIN_STOP], 0);
    fire(10'h004);
    watch(8);
    chk(hi[PIN_STOP] + hi[PIN_START], 0);
    $display("post trigger done");
  endtask

  task automatic t_pre();
    pre = 1'h1;
    fire(10'h001);
    watch(8);
    chk(hi[PIN_START], 0);
    fire(10'h002);
    watch(8);
    chk(hi[PIN_START], TRIG_CYC);
    chk(hi[PIN_STOP], 0);
    fire(10'h004);
    watch(8);
    chk(rises[PIN_STOP], 1);
    chk(hi[PIN_STOP], TRIG_CYC);
    pre = 1'h0;
    $display("pre trigger done");
  endtask

  task automatic t_events();
    int pin [3] = '{PIN_UPD, PIN_WFM, PIN_SCAN};
    int exp [3] = '{8 - TRIG_CYC, TRIG_CYC, TRIG_CYC};
    for (int k = 0; k < 3; k++)
    begin
      fire(10'h008 << k);
      watch(8);
      chk(hi[pin[k]], exp[k]);
    end
    chk(rises[PIN_SCAN], 1);
    busy = 1'h1;
    step(2);
    chk(pin_out[PIN_CONV], 1'h0);
    busy = 1'h0;
    step(2);
    chk(pin_out[PIN_CONV], 1'h1);
    $display("event pins done");
  endtask

  task automatic t_scan();
    s_mode = 1'h1;
    s_en = 1'h1;
    fire(10'h080);
    watch(12);
    chk(hi[PIN_N], 0);
    fire(10'h040);
    step(2);
    chk(scan_clk, 1'h0);
    watch(12, 10'h080);
    chk(hi[PIN_N], SCAN_HI_CYC);
    chk(rises[PIN_N], 1);
    // A conversion during a pulse re-arms once the pulse has ended
    fire(10'h040);
    step(1);
    fire(10'h080);
    step(1);
    fire(10'h040);
    step(8);
    watch(12, 10'h080);
    chk(hi[PIN_N], SCAN_HI_CYC);
    fire(10'h040);
    s_en = 1'h0;
    step(1);
    s_en = 1'h1;
    watch(12, 10'h080);
    chk(hi[PIN_N], 0);
    $display("scan clock done");
  endtask

  task automatic t_strobe();
    s_val = 1'h0;
    fire(10'h100);
    chk(strobe_n, 1'h0);
    step(3);
    chk(strobe_n, 1'h0);
    fire(10'h200);
    chk(strobe_n, 1'h1);
    step(1);
    fire(10'h300);
    chk(strobe_n, 1'h0);
    $display("strobe done");
  endtask

  task automatic t_sel();
    logic e;
    dir = 10'h000;
    ext_en = 10'h3ff;
    ext_val = 10'h2a5;
    int_src = 4'h9;
    step(3);
    chk(pin_oe_n, OE_N_RST);
    chk(pin_sync, 10'h2a5);
    for (int c = 0; c < 16; c++)
    begin
      code = {4{c[3:0]}};
      step(2);
      e = c < 10 ? ext_val[c] : (c < 14 ? int_src[c - 10] : 1'h0);
      chk(sel_q, {4{e}});
    end
    dir = 10'h318;
    ext_en = 10'h0e7;
    code = {4'hd, 4'hc, 4'hb, 4'ha};
    for (int k = 0; k < 2; k++)
    begin
      step(4);
      chk(pin_oe_n, 10'h0e7);
      chk({pin_out[9:8], pin_out[4:3]}, {int_src[1:0], int_src[3:2]});
      int_src = ~int_src;
    end
    dir = 10'h3ff;
    ext_en = 10'h000;
    $display("selectors done");
  endtask

  task automatic t_ded();
    for (int k = 0; k < 8; k++)
    begin
      {a_in, b_in, f_in} = k[2:0];
      step(2);
      chk({a_out, b_out, f_out}, k[2:0]);
    end
    $display("dedicated outputs done");
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles >= 5000)
    begin
      errors++;
      tally_and_finish();
    end
  end

  initial
  begin
    nrst = 1'h0;
    errors = 0;
    check_count = 0;
    cycles = 0;
    dir = 10'h000;
    ext_en = 10'h000;
    ext_val = 10'h000;
    code = '0;
    int_src = 4'h0;
    pulses = 10'h000;
    {pre, busy, s_mode, s_en, s_val, a_in, b_in, f_in} = 8'h00;
    step(8);
    chk(pin_oe_n, OE_N_RST);
    chk(strobe_n, STROBE_RST);
    nrst = 1'h1;
    dir = 10'h3ff;
    $display("reset done");
    t_post();
    t_pre();
    t_events();
    t_scan();
    t_strobe();
    t_sel();
    t_ded();
    tally_and_finish();
  end
endmodule
